// File: include/pcmclk_pkg.sv
// Summary of operation
// - reference at or above 2.048 MHz bypasses the coarse loop, feeds multiplier directly
// - multiplier turns 2.048 MHz into 49.152 MHz for all PCM and GP clocks
// - after reset the multiplier stays bypassed until the frequency command
// - multiplier locks about 750 us after the frequency command
// - without the command the internal clock equals the external input clock
// - on lock the locked bit of the first interrupt status is set
// - coarse counter counts up while reference outruns divided oscillator; drives DAC
// - coarse loop runs from reset for 750 us then holds its code
// - analog loop instability restarts the coarse loop
// - alignment on: PLL outputs and main divider synced to reference edges
// - alignment off: divider follows only the PLL output clock
// - slow reference: alignment resolution comes from the crystal frequency
// - after reset alignment is on as clock slave, off as master
// - slow frame sync, data clock or network reference goes through the coarse loop
// - multiplier may be fed straight from crystal, oscillator or data clock
// - internal clock 2.048 MHz while bypassed, 49.152 MHz once locked
package pcmclk_pkg;
	// timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int LOCK_TIME_US = 750;
	localparam int LOCK_CYCLES = LOCK_TIME_US * 1000000 / CLK_PERIOD_PS;
	// frequencies in kHz
	localparam int REF_FAST_KHZ = 2048;
	localparam int PLL_OUT_KHZ = 49152;
	localparam int XTAL_LO_KHZ = 16384;
	localparam int XTAL_HI_KHZ = 32768;
	localparam int PLL_MULT = PLL_OUT_KHZ / REF_FAST_KHZ;
	localparam int XTAL_LO_DIV = XTAL_LO_KHZ / REF_FAST_KHZ;
	localparam int XTAL_HI_DIV = XTAL_HI_KHZ / REF_FAST_KHZ;
	// register offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_EXTF = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_INFO = 8'h0c;
	// control fields
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_FAST_BIT = 3;
	localparam int CTRL_ALIGN_BIT = 4;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// status fields
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_UNSTABLE_BIT = 1;
	localparam int EXTF_HI_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SRC_FSYNC = 3'h0,
		SRC_DCLK = 3'h1,
		SRC_NET1 = 3'h2,
		SRC_NET2 = 3'h3,
		SRC_XTAL = 3'h4,
		SRC_OSC = 3'h5
	} pcmclk_src_t;

	typedef enum logic [1:0] {
		ST_BYPASS = 2'h0,
		ST_ACQUIRE = 2'h1,
		ST_LOCKED = 2'h3
	} pcmclk_state_t;
endpackage

// File: tb/pcm_clock_generator_pll_control_tb.sv
`timescale 1ns/100ps
module pcm_clock_generator_pll_control_tb;
	import pcmclk_pkg::*;
	localparam int LOCK_N = 20;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} pcmclk_exp_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic clock_slave = 1'b1;
	logic pll_unstable = 1'b0;
	logic ref_ahead = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic ref_edge, xtal_edge, osc_div_edge, pll_edge;
	pcmclk_src_t pll_ref_sel;
	logic coarse_bypass, pll_bypass, core_clk_fast, xtal_hi, align_en, coarse_active, div_wrap;
	logic [7:0] dac_code;
	logic [4:0] div_count;
	logic [31:0] rs = 32'h00000055;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	pcmclk_exp_t rq[$];
	pcmclk_exp_t e_mon;
	logic [1:0] bq[$];

	pcmclk_top #(.LOCK_CYCLES_P(LOCK_N), .DAC_W(8)) i_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.clock_slave, .ref_edge, .xtal_edge, .osc_div_edge, .pll_edge, .pll_unstable, .pll_ref_sel,
		.coarse_bypass, .pll_bypass, .core_clk_fast, .xtal_hi, .align_en, .coarse_active, .dac_code,
		.div_count, .div_wrap
	);
	pcmclk_src_model i_src (.aclk, .xtal_hi, .ref_ahead, .ref_edge, .xtal_edge, .osc_div_edge, .pll_edge);

	// free-running clock
	initial
	begin
		forever #2.5 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	// address and data offered together, each dropped at its own handshake
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit pa;
		bit pw;
		bq.push_back(er);
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		// no cycle count assumed, only the hang guard ends a stuck wait
		while (pa || pw)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				pa = 1'b0;
			if (s_axi_wready)
				pw = 1'b0;
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] em,
		input logic [1:0] er);
		rq.push_back('{ed & em, em, er});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic do_reset(input logic slave);
		aresetn <= 1'b0;
		clock_slave <= slave;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		// alignment default is captured on the first edge after release
		repeat (2) @(posedge aclk);
	endtask

	// answers are matched against the oldest note at each handshake
	always @(posedge aclk)
	begin
		if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
		begin
			e_mon = rq.pop_front();
			chk(s_axi_rdata & e_mon.m, e_mon.d);
			chk({30'h0, s_axi_rresp}, {30'h0, e_mon.r});
		end
		if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
			chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
	end

	// hang guard, the whole sequence needs well under a thousand cycles
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			n_fail++;
			wrap_up();
		end
	end

	initial
	begin
		logic [31:0] d;
		logic [7:0] d0;
		logic [2:0] s;
		logic f;
		int i;
		int n;
		do_reset(1'b1);
		// bypass already follows the cleared slow select; one detector step landed after release
		chk({20'h0, pll_bypass, core_clk_fast, coarse_bypass, coarse_active, dac_code}, 32'h901);
		axi_read(ADDR_CTRL, 32'h10, 32'h1f, RESP_OKAY);
		axi_read(ADDR_INFO, 32'h0, 32'h3, RESP_OKAY);
		repeat (30) @(posedge aclk);
		d0 = dac_code;
		chk({31'h0, coarse_active}, 32'h0);
		chk({31'h0, d0 != 8'h00}, 32'h1);
		repeat (10) @(posedge aclk);
		chk({24'h0, dac_code}, {24'h0, d0});
		$display("test coarse done");
		pll_unstable <= 1'b1;
		@(posedge aclk);
		pll_unstable <= 1'b0;
		repeat (2) @(posedge aclk);
		chk({31'h0, coarse_active}, 32'h1);
		axi_read(ADDR_STAT, 32'h2, 32'h2, RESP_OKAY);
		axi_write(ADDR_STAT, 32'h2, RESP_OKAY);
		axi_read(ADDR_STAT, 32'h0, 32'h2, RESP_OKAY);
		$display("test unstable done");
		repeat (3) @(posedge aclk);
		chk({31'h0, pll_bypass}, 32'h1);
		d = rnd();
		axi_write(ADDR_EXTF, d, RESP_OKAY);
		repeat (8) @(posedge aclk);
		chk({30'h0, pll_bypass, core_clk_fast}, 32'h2);
		axi_read(ADDR_INFO, 32'h1, 32'h3, RESP_OKAY);
		for (i = 0; i < 40 && pll_bypass !== 1'b0; i++)
			@(posedge aclk);
		chk({30'h0, pll_bypass, core_clk_fast}, 32'h1);
		chk({31'h0, xtal_hi}, {31'h0, d[0]});
		axi_read(ADDR_STAT, 32'h1, 32'h1, RESP_OKAY);
		axi_read(ADDR_INFO, 32'h3, 32'h3, RESP_OKAY);
		axi_write(ADDR_EXTF, d, RESP_OKAY);
		@(posedge aclk);
		chk({31'h0, pll_bypass}, 32'h1);
		$display("test lock done");
		// every source with slow and fast declared rate; slow keeps alignment off
		for (i = 0; i < 12; i++)
		begin
			s = 3'(i % 6);
			f = (i > 5);
			axi_write(ADDR_CTRL, {27'h0, f, f, s}, RESP_OKAY);
			repeat (2) @(posedge aclk);
			chk({29'h0, pll_ref_sel}, {29'h0, s});
			chk({31'h0, coarse_bypass}, {31'h0, f || s >= 3'h4});
			chk({31'h0, align_en}, {31'h0, f});
			axi_read(ADDR_CTRL, {27'h0, f, f, s}, 32'h1f, RESP_OKAY);
		end
		$display("test select done");
		axi_write(ADDR_CTRL, 32'h0, RESP_OKAY);
		for (i = 0; i < 100 && div_wrap !== 1'b1; i++)
			@(posedge aclk);
		chk({31'h0, div_wrap}, 32'h1);
		chk({27'h0, div_count}, 32'h0);
		$display("test divider done");
		// slow reference aligned on the crystal grid restarts the divider before it can wrap
		axi_write(ADDR_CTRL, 32'h10, RESP_OKAY);
		repeat (40) @(posedge aclk);
		n = 0;
		for (i = 0; i < 100; i++)
		begin
			@(posedge aclk);
			if (div_wrap === 1'b1)
				n++;
		end
		chk(n, 32'h0);
		$display("test slow alignment done");
		axi_write(8'h10, rnd(), RESP_SLVERR);
		axi_read(8'h10, 32'h0, 32'hffffffff, RESP_SLVERR);
		$display("test unmapped done");
		do_reset(1'b0);
		chk({31'h0, pll_bypass}, 32'h1);
		axi_read(ADDR_CTRL, 32'h0, 32'h1f, RESP_OKAY);
		axi_read(ADDR_STAT, 32'h0, 32'h1, RESP_OKAY);
		$display("test second reset done");
		wrap_up();
	end
endmodule // pcm_clock_generator_pll_control_tb

// File: tb/pcmclk_src_model.sv
`timescale 1ns/100ps
module pcmclk_src_model (
	input wire logic aclk,
	input wire logic xtal_hi,
	input wire logic ref_ahead,
	output logic ref_edge,
	output logic xtal_edge,
	output logic osc_div_edge,
	output logic pll_edge
);
	logic [3:0] cnt_q = 4'h0;
	// sources run free from power-up, reset does not stop a crystal
	always_ff @(posedge aclk)
	begin
		cnt_q <= cnt_q + 4'h1;
	end
	// crystal edges twice as dense for the high crystal choice
	assign xtal_edge = xtal_hi ? cnt_q[0] : (cnt_q[1:0] == 2'h3);
	// fast reference outruns the divided oscillator so the coarse counter climbs
	assign ref_edge = ref_ahead ? cnt_q[0] : (cnt_q == 4'hf);
	assign osc_div_edge = (cnt_q[2:0] == 3'h7);
	assign pll_edge = cnt_q[0];
endmodule // pcmclk_src_model

// File: verilog/pcmclk_coarse_loop.sv
`timescale 1ns/100ps
module pcmclk_coarse_loop
	import pcmclk_pkg::*;
#(
	parameter int LOCK_CYCLES_P = pcmclk_pkg::LOCK_CYCLES,
	parameter int DAC_W = 8
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic restart,
	input wire logic ref_edge,
	input wire logic osc_div_edge,
	output logic active,
	output logic [DAC_W-1:0] dac_code
);
	logic [17:0] timer_q;
	logic active_q;
	logic [DAC_W-1:0] code_q;

	// enable window: open from reset or restart, shut after the lock time
	always_ff @(posedge aclk)
	begin
		if (!aresetn || restart)
		begin
			timer_q <= 18'h00000;
			active_q <= 1'b1;
		end
		else if (active_q)
		begin
			if (timer_q == 18'(LOCK_CYCLES_P - 1))
				active_q <= 1'b0;
			else
				timer_q <= timer_q + 18'h00001;
		end
	end

	// frequency detector steers the counter; saturates to avoid wrap
	always_ff @(posedge aclk)
	begin
		if (!aresetn || restart)
			code_q <= '0;
		else if (active_q && ref_edge && !osc_div_edge && !(&code_q))
			code_q <= code_q + DAC_W'(1);
		else if (active_q && osc_div_edge && !ref_edge && (|code_q))
			code_q <= code_q - DAC_W'(1);
	end

	assign active = active_q;
	assign dac_code = code_q;

	a_coarse_up: assert property (@(posedge aclk) disable iff (!aresetn)
		active_q && !restart && ref_edge && !osc_div_edge && !(&code_q) |=> code_q == $past(code_q) + 1'b1)
		else $error("coarse counter did not step up");
	a_coarse_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!active_q && !restart |=> !active_q && $stable(code_q))
		else $error("coarse code moved after window closed");
	a_coarse_restart: assert property (@(posedge aclk) disable iff (!aresetn)
		restart |=> active_q && timer_q == 18'h00000 && code_q == '0)
		else $error("coarse loop not restarted");
endmodule // pcmclk_coarse_loop

// File: verilog/pcmclk_phase_align.sv
`timescale 1ns/100ps
module pcmclk_phase_align
	import pcmclk_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic align_en,
	input wire logic ref_slow,
	input wire logic xtal_hi,
	input wire logic ref_edge,
	input wire logic xtal_edge,
	input wire logic pll_edge,
	output logic [4:0] div_count,
	output logic div_wrap
);
	logic [4:0] res_q;
	logic pend_q;
	logic [4:0] div_q;
	logic wrap_q;
	logic res_tick;
	logic sync_now;

	// slow references align only on crystal-derived 2.048 MHz grid
	assign res_tick = xtal_edge && (res_q == (xtal_hi ? 5'(XTAL_HI_DIV - 1) : 5'(XTAL_LO_DIV - 1)));
	assign sync_now = align_en && (ref_slow ? (pend_q && res_tick) : ref_edge);

	// resolution divider on the crystal
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			res_q <= 5'h00;
		else if (res_tick)
			res_q <= 5'h00;
		else if (xtal_edge)
			res_q <= res_q + 5'h01;
	end

	// remembers a slow reference edge until the next grid point
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !align_en)
			pend_q <= 1'b0;
		else if (ref_slow && ref_edge)
			pend_q <= 1'b1;
		else if (res_tick)
			pend_q <= 1'b0;
	end

	// main divider: restarted by alignment, else stepped by pll output only
	always_ff @(posedge aclk)
	begin
		if (!aresetn || sync_now)
		begin
			div_q <= 5'h00;
			wrap_q <= 1'b0;
		end
		else if (pll_edge)
		begin
			wrap_q <= (div_q == 5'(PLL_MULT - 1));
			div_q <= (div_q == 5'(PLL_MULT - 1)) ? 5'h00 : div_q + 5'h01;
		end
		else
			wrap_q <= 1'b0;
	end

	assign div_count = div_q;
	assign div_wrap = wrap_q;

	a_div_align: assert property (@(posedge aclk) disable iff (!aresetn)
		align_en && !ref_slow && ref_edge |=> div_q == 5'h00)
		else $error("divider not aligned to reference");
	a_div_free: assert property (@(posedge aclk) disable iff (!aresetn)
		!align_en && !pll_edge |=> $stable(div_q))
		else $error("divider moved without pll edge");
	a_slow_align: assert property (@(posedge aclk) disable iff (!aresetn)
		align_en && ref_slow && pend_q && res_tick |=> div_q == 5'h00)
		else $error("slow reference not aligned on grid");
endmodule // pcmclk_phase_align

// File: verilog/pcmclk_top.sv
`timescale 1ns/100ps
module pcmclk_top
	import pcmclk_pkg::*;
#(
	parameter int LOCK_CYCLES_P = pcmclk_pkg::LOCK_CYCLES,
	parameter int DAC_W = 8
)(
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// clock sources as synchronous edge pulses
	input wire logic clock_slave,
	input wire logic ref_edge,
	input wire logic xtal_edge,
	input wire logic osc_div_edge,
	input wire logic pll_edge,
	input wire logic pll_unstable,
	// clock generator steering
	output pcmclk_pkg::pcmclk_src_t pll_ref_sel,
	output logic coarse_bypass,
	output logic pll_bypass,
	output logic core_clk_fast,
	output logic xtal_hi,
	output logic align_en,
	output logic coarse_active,
	output logic [DAC_W-1:0] dac_code,
	output logic [4:0] div_count,
	output logic div_wrap
);
	import pcmclk_pkg::*;

	logic [7:0] ctrl_q;
	logic xtal_hi_q;
	logic init_q;
	pcmclk_state_t state_q;
	pcmclk_state_t state_d;
	logic [17:0] lock_q;
	logic [1:0] stat_q;
	logic coarse_byp_q;
	logic aw_full_q;
	logic w_full_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic wr_go;
	logic wr_lane0;
	logic extf_cmd;
	logic lock_done;
	logic stat_clr_lock;
	logic stat_clr_unst;
	logic ref_slow;
	pcmclk_src_t sel;

	// write path: address and data latched independently, response after both
	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready = !w_full_q && !bvalid_q;
	assign wr_go = aw_full_q && w_full_q && !bvalid_q;
	assign wr_lane0 = wr_go && w_strb_q[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_full_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
		else if (wr_go)
			aw_full_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_full_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_full_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
		else if (wr_go)
			w_full_q <= 1'b0;
	end

	// write response; unmapped offsets answer slverr
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= (aw_addr_q[7:2] <= ADDR_INFO[7:2]) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// control: source, fast reference, alignment; alignment default caught after reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q <= CTRL_RST;
			init_q <= 1'b0;
		end
		else if (!init_q)
		begin
			init_q <= 1'b1;
			ctrl_q[CTRL_ALIGN_BIT] <= clock_slave;
		end
		else if (wr_lane0 && aw_addr_q[7:2] == ADDR_CTRL[7:2])
			ctrl_q <= w_data_q[7:0];
	end

	assign extf_cmd = wr_lane0 && aw_addr_q[7:2] == ADDR_EXTF[7:2];

	// crystal frequency, normally the first thing software writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			xtal_hi_q <= 1'b0;
		else if (extf_cmd)
			xtal_hi_q <= w_data_q[EXTF_HI_BIT];
	end

	assign sel = pcmclk_src_t'(ctrl_q[CTRL_SEL_LSB +: 3]);
	assign ref_slow = !ctrl_q[CTRL_FAST_BIT];

	// coarse loop only for slow frame sync, data clock and network references
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			coarse_byp_q <= 1'b1;
		else
			coarse_byp_q <= !ref_slow || sel == SRC_XTAL || sel == SRC_OSC;
	end

	// lock sequencer: bypass until command, then timed acquisition
	assign lock_done = state_q == ST_ACQUIRE && lock_q == 18'(LOCK_CYCLES_P - 1);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_BYPASS:
				if (extf_cmd)
					state_d = ST_ACQUIRE;
			ST_ACQUIRE:
				if (extf_cmd)
					state_d = ST_ACQUIRE;
				else if (lock_done)
					state_d = ST_LOCKED;
			ST_LOCKED:
				if (extf_cmd)
					state_d = ST_ACQUIRE;
			default:
				state_d = ST_BYPASS;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_q <= ST_BYPASS;
		else
			state_q <= state_d;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || extf_cmd || state_q != ST_ACQUIRE)
			lock_q <= 18'h00000;
		else
			lock_q <= lock_q + 18'h00001;
	end

	// sticky status, set beats a write-one clear
	assign stat_clr_lock = wr_lane0 && aw_addr_q[7:2] == ADDR_STAT[7:2] && w_data_q[STAT_LOCK_BIT];
	assign stat_clr_unst = wr_lane0 && aw_addr_q[7:2] == ADDR_STAT[7:2] && w_data_q[STAT_UNSTABLE_BIT];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			stat_q <= 2'h0;
		else
		begin
			if (lock_done && !extf_cmd)
				stat_q[STAT_LOCK_BIT] <= 1'b1;
			else if (stat_clr_lock)
				stat_q[STAT_LOCK_BIT] <= 1'b0;
			if (pll_unstable)
				stat_q[STAT_UNSTABLE_BIT] <= 1'b1;
			else if (stat_clr_unst)
				stat_q[STAT_UNSTABLE_BIT] <= 1'b0;
		end
	end

	// read path, one cycle from address to data
	assign s_axi_arready = !rvalid_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_q)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			case (s_axi_araddr[7:2])
				ADDR_CTRL[7:2]: rdata_q <= {24'h000000, ctrl_q};
				ADDR_EXTF[7:2]: rdata_q <= {31'h00000000, xtal_hi_q};
				ADDR_STAT[7:2]: rdata_q <= {30'h00000000, stat_q};
				ADDR_INFO[7:2]: rdata_q <= {16'h0000, 8'(dac_code), 4'h0, coarse_active, coarse_byp_q, state_q};
				default:
				begin
					rdata_q <= 32'h00000000;
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// coarse frequency loop; instability kicks it back to start
	pcmclk_coarse_loop #(
		.LOCK_CYCLES_P(LOCK_CYCLES_P),
		.DAC_W(DAC_W)
	) u_coarse (
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(pll_unstable),
		.ref_edge(ref_edge),
		.osc_div_edge(osc_div_edge),
		.active(coarse_active),
		.dac_code(dac_code)
	);

	// main divider alignment
	pcmclk_phase_align u_align (
		.aclk(aclk),
		.aresetn(aresetn),
		.align_en(ctrl_q[CTRL_ALIGN_BIT]),
		.ref_slow(ref_slow),
		.xtal_hi(xtal_hi_q),
		.ref_edge(ref_edge),
		.xtal_edge(xtal_edge),
		.pll_edge(pll_edge),
		.div_count(div_count),
		.div_wrap(div_wrap)
	);

	assign pll_ref_sel = sel;
	assign coarse_bypass = coarse_byp_q;
	assign pll_bypass = state_q != ST_LOCKED;
	assign core_clk_fast = state_q == ST_LOCKED;
	assign xtal_hi = xtal_hi_q;
	assign align_en = ctrl_q[CTRL_ALIGN_BIT];

	sequence s_cmd;
		extf_cmd;
	endsequence

	sequence s_acquire;
		state_q == ST_ACQUIRE && lock_q == 18'h00000;
	endsequence

	a_bypass_until_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_BYPASS && !extf_cmd |=> state_q == ST_BYPASS && pll_bypass)
		else $error("pll left bypass without command");
	a_cmd_starts: assert property (@(posedge aclk) disable iff (!aresetn)
		s_cmd |=> s_acquire)
		else $error("command did not start acquisition");
	a_lock_expiry: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_done && !extf_cmd |=> state_q == ST_LOCKED ##1 stat_q[STAT_LOCK_BIT] || state_q != ST_LOCKED)
		else $error("timer expiry did not lock");
	a_lock_status: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_ACQUIRE && state_d == ST_LOCKED |=> stat_q[STAT_LOCK_BIT])
		else $error("locked bit not set on lock");
	a_clk_rate: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(core_clk_fast) |-> !pll_bypass && stat_q[STAT_LOCK_BIT] && $past(lock_done))
		else $error("fast clock without completed lock");
	a_fast_ref_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q[CTRL_FAST_BIT] |=> coarse_byp_q)
		else $error("fast reference used coarse loop");
	a_slow_ref_coarse: assert property (@(posedge aclk) disable iff (!aresetn)
		ref_slow && sel <= SRC_NET2 |=> !coarse_byp_q)
		else $error("slow reference skipped coarse loop");
	a_align_default: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |=> ctrl_q[CTRL_ALIGN_BIT] == $past(clock_slave))
		else $error("alignment default wrong after reset");
	a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		bvalid_q && !s_axi_bready |=> bvalid_q && $stable(bresp_q))
		else $error("write response dropped early");
endmodule // pcmclk_top
